// File: gpib_instrument.sv
// Operation
// - Bytes under attention are interface commands
// - Controller asserts attention only without data-valid; OP_TAKE_SYNC waits for it, OP_TAKE_ASYNC and OP_PPOLL do not check
// - Take-control passes charge on attention release
// - Serial poll may start any time
// - Poll: untalk, unlisten, enable, talk address
// - Talker in poll mode sends one status byte
// - Bit seven flags service, rest give reason
// - Release service request once polled
// - Controller polls until service request clears
// - Parallel poll answers one bit unaddressed
// - Configure: unlisten, listen, configure, enable byte
// - Enable byte X110SPPP gives sense and line
// - Drive line only when status equals sense
// - Poll with end-or-identify and attention asserted
// - End poll: release end-or-identify, then attention
// - Configuration persists across polls
// - Unconfigure clears every configuration
// - Disable stops selected answers, stays configured
// - Source waits ready plus two microseconds
`timescale 1ns/1ps
`include "gpib_consts.svh"
module gpib_instrument (
    input wire logic clk,
    input wire logic sys_rst,
    gpib_bus_if.dev link,
    input wire logic [4:0] my_addr,
    input wire logic svc_req,
    input wire logic [6:0] svc_reason,
    input wire logic ist,
    output logic cic,
    output logic srq_active,
    output logic polled,
    output logic pp_configured,
    output logic pp_enabled,
    output logic talk_active
);
    import gpib_pkg::*;

    dev_state_t r_ff;
    dev_state_t nxt_r;
    lines_t in;
    logic [6:0] c;

    // Primary address match for talk and listen groups
    function automatic logic addr_hit(input logic [6:0] cmd_b, input logic [4:0] addr);
        return cmd_b[4:0] == addr;
    endfunction

    // Primary group in bits 6:5 of a command
    function automatic logic pri_grp(input logic [6:0] cmd_b, input logic [1:0] grp);
        return cmd_b[6:5] == grp;
    endfunction

    // Secondary group in bits 6:4 of a command
    function automatic logic sec_grp(input logic [6:0] cmd_b, input logic [2:0] grp);
        return cmd_b[6:4] == grp;
    endfunction

    // Settle count reached after ready-for-data was seen released
    function automatic logic settle_done(input logic [`CNT_W-1:0] cnt_v);
        return cnt_v == `CNT_W'(`SETTLE_CYC - 1);
    endfunction

    always_comb begin
        nxt_r = r_ff;
        in = r_ff.s2;
        c = in.dio[6:0];
        // Bus lines pass two stages before any decode
        nxt_r.s1 = link.bus;
        nxt_r.s2 = r_ff.s1;
        nxt_r.atn_prev = in.atn;
        nxt_r.polled = 1'b0;

        if (!in.atn) begin
            nxt_r.acc_hold = 1'b0;
        end else if (r_ff.acc_hold) begin
            if (!in.dav) begin
                nxt_r.acc_hold = 1'b0;
            end
        end else if (in.dav) begin
            nxt_r.acc_hold = 1'b1;
            nxt_r.pp_sel = 1'b0;
            if (c == `CMD_UNT) begin
                nxt_r.talk = 1'b0;
            end else if (c == `CMD_UNL) begin
                nxt_r.listen = 1'b0;
            end else if (c == `CMD_SPE) begin
                nxt_r.spmode = 1'b1;
            end else if (c == `CMD_SPD) begin
                nxt_r.spmode = 1'b0;
            end else if (c == `CMD_PPU) begin
                nxt_r.pp_cfg = 1'b0;
                nxt_r.pp_en = 1'b0;
            end else if (c == `CMD_PPC) begin
                nxt_r.pp_sel = r_ff.listen;
            end else if (c == `CMD_TCT) begin
                nxt_r.tct = r_ff.talk;
            end else if (pri_grp(c, `GRP_TALK)) begin
                nxt_r.talk = addr_hit(c, my_addr);
                nxt_r.tst = T_IDLE;
            end else if (pri_grp(c, `GRP_LISTEN)) begin
                if (addr_hit(c, my_addr)) begin
                    nxt_r.listen = 1'b1;
                end
            end else if (sec_grp(c, `GRP_PPE) && r_ff.pp_sel) begin
                nxt_r.pp_cfg = 1'b1;
                nxt_r.pp_en = 1'b1;
                nxt_r.sense = c[`PPE_SENSE_BIT];
                nxt_r.pp_line = c[`PPE_LINE_MSB:0];
            end else if (sec_grp(c, `GRP_PPD) && r_ff.pp_sel) begin
                nxt_r.pp_en = 1'b0;
            end
        end

        if (r_ff.atn_prev && !in.atn && r_ff.tct) begin
            nxt_r.cic = 1'b1;
            nxt_r.tct = 1'b0;
        end

        // single status byte as serial poll talker
        if (in.atn) begin
            nxt_r.tst = T_IDLE;
        end else begin
            case (r_ff.tst)
                T_IDLE: begin
                    if (r_ff.talk && r_ff.spmode) begin
                        nxt_r.tx = {r_ff.rsv, r_ff.reason};
                        nxt_r.cnt = '0;
                        nxt_r.tst = T_SETTLE;
                    end
                end
                T_SETTLE: begin
                    if (in.nrfd) begin
                        nxt_r.cnt = '0;
                    end else if (settle_done(r_ff.cnt)) begin
                        nxt_r.tst = T_DAV;
                    end else begin
                        nxt_r.cnt = r_ff.cnt + `CNT_W'(1);
                    end
                end
                T_DAV: begin
                    if (!in.ndac) begin
                        nxt_r.tst = T_DONE;
                        nxt_r.polled = 1'b1;
                        if (r_ff.tx[`SB_RSV_BIT]) begin
                            nxt_r.rsv = 1'b0;
                        end
                    end
                end
                T_DONE: begin
                    // One byte per addressing, until attention returns
                    nxt_r.tst = T_DONE;
                end
                default: begin
                    nxt_r.tst = T_DONE;
                end
            endcase
        end

        // Set wins over the poll clear
        if (svc_req) begin
            nxt_r.rsv = 1'b1;
            nxt_r.reason = svc_reason;
        end

        nxt_r.drv = '0;
        nxt_r.drv.srq = nxt_r.rsv;
        // Acceptor under attention: ready until a byte is held
        if (in.atn) begin
            nxt_r.drv.ndac = !nxt_r.acc_hold;
            nxt_r.drv.nrfd = nxt_r.acc_hold;
        end
        // Talker drives the byte from settle through data-valid
        if (nxt_r.tst == T_SETTLE || nxt_r.tst == T_DAV) begin
            nxt_r.drv.dio = nxt_r.tx;
        end
        nxt_r.drv.dav = (nxt_r.tst == T_DAV);
        if (in.atn && in.eoi && nxt_r.pp_cfg && nxt_r.pp_en && ist == nxt_r.sense) begin
            nxt_r.drv.dio[nxt_r.pp_line] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.dev_o = '1;
    assign link.dev_oe_n = ~r_ff.drv;
    assign cic = r_ff.cic;
    assign srq_active = r_ff.rsv;
    assign polled = r_ff.polled;
    assign pp_configured = r_ff.pp_cfg;
    assign pp_enabled = r_ff.pp_en;
    assign talk_active = r_ff.talk;
endmodule

// File: gpib_consts.svh
`ifndef GPIB_CONSTS_SVH
`define GPIB_CONSTS_SVH

// Interface commands, low seven bits (bit 7 is ignored)
`define CMD_UNT 7'h5f
`define CMD_UNL 7'h3f
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_PPC 7'h05
`define CMD_PPU 7'h15
`define CMD_TCT 7'h09
`define CMD_PPD 7'h70
// Address groups in bits 6:5, secondary groups in bits 6:4
`define GRP_TALK 2'h2
`define GRP_LISTEN 2'h1
`define GRP_PPE 3'h6
`define GRP_PPD 3'h7
// Status byte service bit and enable byte fields
`define SB_RSV_BIT 7
`define PPE_SENSE_BIT 3
`define PPE_LINE_MSB 2
// Timing
`define CLK_NS 50
`define SETTLE_NS 2000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define PP_WAIT_NS 2000
`define PP_WAIT_CYC ((`PP_WAIT_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 6

`endif

// File: gpib_pkg.sv
package gpib_pkg;
    `include "gpib_consts.svh"

    typedef struct packed {
        logic atn;
        logic eoi;
        logic srq;
        logic dav;
        logic nrfd;
        logic ndac;
        logic [7:0] dio;
    } lines_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_SETTLE = 2'b01,
        T_DAV = 2'b11,
        T_DONE = 2'b10
    } talk_st_t;

    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_ATNW = 3'b001,
        C_SETL = 3'b011,
        C_DAV = 3'b010,
        C_RD = 3'b110,
        C_RDH = 3'b111,
        C_PP = 3'b101,
        C_PPE = 3'b100
    } ctl_st_t;

    typedef enum logic [2:0] {
        OP_TAKE_SYNC = 3'h0,
        OP_TAKE_ASYNC = 3'h1,
        OP_RELEASE = 3'h2,
        OP_SEND = 3'h3,
        OP_READ = 3'h4,
        OP_PPOLL = 3'h5
    } op_t;

    typedef struct packed {
        lines_t s1;
        lines_t s2;
        lines_t drv;
        logic acc_hold;
        logic atn_prev;
        logic talk;
        logic listen;
        logic spmode;
        logic tct;
        logic cic;
        logic pp_sel;
        logic pp_cfg;
        logic pp_en;
        logic sense;
        logic [2:0] pp_line;
        logic rsv;
        logic [6:0] reason;
        logic [7:0] tx;
        talk_st_t tst;
        logic [`CNT_W-1:0] cnt;
        logic polled;
    } dev_state_t;

    typedef struct packed {
        lines_t s1;
        lines_t s2;
        lines_t drv;
        ctl_st_t st;
        logic [`CNT_W-1:0] cnt;
        logic [7:0] tx;
        logic [7:0] rx;
        logic rx_valid;
        logic cic;
        logic pass_pend;
    } ctl_state_t;
endpackage

// File: gpib_bus_if.sv
`timescale 1ns/1ps
interface gpib_bus_if;
    import gpib_pkg::*;
    lines_t dev_o;
    lines_t dev_oe_n;
    lines_t ctl_o;
    lines_t ctl_oe_n;
    lines_t bus;

    // Wired-OR of asserted levels; a line is asserted if any party drives it
    assign bus = (dev_o & ~dev_oe_n) | (ctl_o & ~ctl_oe_n);

    modport dev (output dev_o, output dev_oe_n, input bus);
    modport ctl (output ctl_o, output ctl_oe_n, input bus);
endinterface

// File: gpib_controller.sv
`timescale 1ns/1ps
`include "gpib_consts.svh"
module gpib_controller (
    input wire logic clk,
    input wire logic sys_rst,
    gpib_bus_if.ctl link,
    input wire logic cmd_valid,
    input wire gpib_pkg::op_t cmd_op,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic srq_seen,
    output logic cic
);
    import gpib_pkg::*;

    ctl_state_t r_ff;
    ctl_state_t nxt_r;
    lines_t in;

    always_comb begin
        nxt_r = r_ff;
        in = r_ff.s2;
        nxt_r.s1 = link.bus;
        nxt_r.s2 = r_ff.s1;
        nxt_r.rx_valid = 1'b0;
        case (r_ff.st)
            C_IDLE: begin
                // no op waits on service request
                if (cmd_valid && r_ff.cic) begin
                    case (cmd_op)
                        OP_TAKE_SYNC: nxt_r.st = C_ATNW;
                        OP_TAKE_ASYNC: nxt_r.drv.atn = 1'b1;
                        OP_RELEASE: begin
                            nxt_r.drv.atn = 1'b0;
                            nxt_r.drv.eoi = 1'b0;
                            // charge leaves on release after take-control
                            if (r_ff.pass_pend) begin
                                nxt_r.cic = 1'b0;
                            end
                        end
                        OP_SEND: begin
                            // sequences are built from single sends
                            nxt_r.tx = cmd_data;
                            nxt_r.cnt = '0;
                            nxt_r.st = C_SETL;
                        end
                        OP_READ: nxt_r.st = C_RD;
                        OP_PPOLL: begin
                            nxt_r.drv.atn = 1'b1;
                            nxt_r.drv.eoi = 1'b1;
                            nxt_r.cnt = '0;
                            nxt_r.st = C_PP;
                        end
                        default: nxt_r.st = C_IDLE;
                    endcase
                end
            end
            C_ATNW: begin
                if (!in.dav) begin
                    nxt_r.drv.atn = 1'b1;
                    nxt_r.st = C_IDLE;
                end
            end
            C_SETL: begin
                if (in.nrfd) begin
                    nxt_r.cnt = '0;
                end else if (r_ff.cnt == `CNT_W'(`SETTLE_CYC - 1)) begin
                    nxt_r.st = C_DAV;
                end else begin
                    nxt_r.cnt = r_ff.cnt + `CNT_W'(1);
                end
            end
            C_DAV: begin
                if (!in.ndac) begin
                    nxt_r.pass_pend = r_ff.drv.atn && (r_ff.tx[6:0] == `CMD_TCT);
                    nxt_r.st = C_IDLE;
                end
            end
            C_RD: begin
                if (in.dav) begin
                    nxt_r.rx = in.dio;
                    nxt_r.rx_valid = 1'b1;
                    nxt_r.st = C_RDH;
                end
            end
            C_RDH: begin
                if (!in.dav) begin
                    nxt_r.st = C_IDLE;
                end
            end
            C_PP: begin
                if (r_ff.cnt == `CNT_W'(`PP_WAIT_CYC - 1)) begin
                    nxt_r.rx = in.dio;
                    nxt_r.rx_valid = 1'b1;
                    nxt_r.drv.eoi = 1'b0;
                    nxt_r.st = C_PPE;
                end else begin
                    nxt_r.cnt = r_ff.cnt + `CNT_W'(1);
                end
            end
            default: begin
                nxt_r.drv.atn = 1'b0;
                nxt_r.st = C_IDLE;
            end
        endcase

        nxt_r.drv.dav = (nxt_r.st == C_DAV);
        nxt_r.drv.dio = (nxt_r.st == C_SETL || nxt_r.st == C_DAV) ? nxt_r.tx : 8'h00;
        // Hold a talker off unless reading; never stall our own sends
        nxt_r.drv.nrfd = !nxt_r.drv.atn && nxt_r.st != C_RD && nxt_r.st != C_SETL && nxt_r.st != C_DAV;
        nxt_r.drv.ndac = !nxt_r.drv.atn && nxt_r.st != C_RDH && nxt_r.st != C_SETL && nxt_r.st != C_DAV;
        nxt_r.drv.srq = 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_ff <= '0;
            r_ff.cic <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.ctl_o = '1;
    assign link.ctl_oe_n = ~r_ff.drv;
    assign cmd_ready = (r_ff.st == C_IDLE) && r_ff.cic;
    assign rd_valid = r_ff.rx_valid;
    assign rd_data = r_ff.rx;
    assign srq_seen = r_ff.s2.srq;
    assign cic = r_ff.cic;
endmodule

// File: gpib_poll_monitor.sv
`timescale 1ns/1ps
`include "gpib_consts.svh"
module gpib_poll_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire gpib_pkg::lines_t dev_o,
    input wire gpib_pkg::lines_t dev_oe_n,
    input wire gpib_pkg::lines_t ctl_o,
    input wire gpib_pkg::lines_t ctl_oe_n,
    input wire gpib_pkg::lines_t bus
);
    import gpib_pkg::*;
    logic [`CNT_W-1:0] free_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Cycles since ready-for-data was last released
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            free_ff <= '0;
        end else if (bus.nrfd) begin
            free_ff <= '0;
        end else if (free_ff != '1) begin
            free_ff <= free_ff + 1'b1;
        end
    end
    chk_cmd_no_data: assert property ((bus.atn && !bus.eoi) [*5] |-> &dev_oe_n.dio)
        else $error("device drives data under attention");
    chk_sync_take: assert property ($fell(ctl_oe_n.atn) |-> !$past(bus.dav))
        else $error("attention taken during data valid");
    chk_pp_one_bit: assert property (bus.atn && bus.eoi |-> $onehot0(~dev_oe_n.dio))
        else $error("parallel answer uses more than one line");
    chk_pp_drop: assert property ($fell(bus.eoi) |-> ##[0:4] &dev_oe_n.dio)
        else $error("parallel answer held after poll end");
    chk_srq_release: assert property ($rose(dev_oe_n.dav) |-> ##[0:4] dev_oe_n.srq)
        else $error("service request kept after poll");
    chk_dev_settle: assert property ($fell(dev_oe_n.dav) |-> free_ff >= `SETTLE_CYC)
        else $error("device data valid too early");
    chk_ctl_settle: assert property ($fell(ctl_oe_n.dav) |-> free_ff >= `SETTLE_CYC)
        else $error("controller data valid too early");
    chk_eoi_with_atn: assert property (!ctl_oe_n.eoi |-> !ctl_oe_n.atn)
        else $error("end-or-identify without attention");
    chk_pp_span: assert property ($fell(ctl_oe_n.eoi) |-> (!ctl_oe_n.eoi && !ctl_oe_n.atn) [*8])
        else $error("parallel poll too short");
    chk_eoi_first: assert property ($rose(ctl_oe_n.atn) |-> $past(ctl_oe_n.eoi))
        else $error("attention released before end-or-identify");
    chk_status_hold: assert property (!dev_oe_n.dav |-> $stable(dev_oe_n.dio))
        else $error("status byte changed during handshake");
    cover property ($fell(dev_oe_n.dav));
    cover property (bus.atn && bus.eoi && !(&dev_oe_n.dio));
    cover property ($fell(ctl_oe_n.atn));
endmodule

// File: gpib_poll_and_control_tb.sv
`timescale 1ns/1ps
`include "gpib_consts.svh"
module gpib_poll_and_control_tb;
    import gpib_pkg::*;
    localparam logic [4:0] ADDR = 5'h0a;
    logic clk, sys_rst, svc_req, ist, cmd_valid;
    logic [6:0] svc_reason;
    op_t cmd_op;
    logic [7:0] cmd_data, rd_data, rd_got;
    logic i_cic, srq_active, pp_configured, pp_enabled;
    logic cmd_ready, rd_valid, srq_seen, c_cic;
    logic polled_w, talk_on;
    logic [3:0] poll_cnt;
    int err_total, cmp_count, cycles;
    gpib_bus_if link_if ();
    gpib_instrument gpib_instrument_inst (.clk(clk), .sys_rst(sys_rst), .link(link_if.dev),
        .my_addr(ADDR), .svc_req(svc_req), .svc_reason(svc_reason), .ist(ist), .cic(i_cic),
        .srq_active(srq_active), .polled(polled_w), .pp_configured(pp_configured),
        .pp_enabled(pp_enabled), .talk_active(talk_on));
    gpib_controller gpib_controller_inst (.clk(clk), .sys_rst(sys_rst), .link(link_if.ctl),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .srq_seen(srq_seen), .cic(c_cic));
    gpib_poll_monitor gpib_poll_monitor_inst (.clk(clk), .sys_rst(sys_rst), .dev_o(link_if.dev_o),
        .dev_oe_n(link_if.dev_oe_n), .ctl_o(link_if.ctl_o), .ctl_oe_n(link_if.ctl_oe_n),
        .bus(link_if.bus));

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmd(input op_t op, input logic [7:0] data);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_data = data;
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1 && c_cic === 1'b1) @(negedge clk);
    endtask

    // Take attention, then send each byte as a command
    task automatic sends(input logic [6:0] q[$]);
        cmd(OP_TAKE_SYNC, 8'h00);
        foreach (q[i]) cmd(OP_SEND, {1'b0, q[i]});
    endtask

    task automatic ppoll(input logic level, input logic [7:0] exp);
        @(negedge clk);
        ist = level;
        cmd(OP_PPOLL, 8'h00);
        check("pp byte", rd_got, exp);
    endtask

    task automatic t_serial();
        @(negedge clk);
        svc_reason = 7'h2b;
        svc_req = 1'b1;
        @(negedge clk);
        svc_req = 1'b0;
        repeat (6) @(negedge clk);
        check("srq line", link_if.bus.srq, 1'b1);
        check("srq seen", srq_seen, 1'b1);
        // Second pass polls with no request pending
        for (int n = 0; n < 2; n++) begin
            sends('{`CMD_UNT, `CMD_UNL, `CMD_SPE, {2'b10, ADDR}});
            cmd(OP_RELEASE, 8'h00);
            cmd(OP_READ, 8'h00);
            check("status rsv", rd_got[`SB_RSV_BIT], n == 0);
            if (n == 0) check("reason", rd_got[6:0], 7'h2b);
            check("polled", poll_cnt, 4'(n + 1));
            check("talker", talk_on, 1'b1);
            repeat (6) @(negedge clk);
            check("srq drop", {link_if.bus.srq, srq_active}, 2'b00);
        end
        check("srq clear", srq_seen, 1'b0);
        cmd(OP_TAKE_ASYNC, 8'h00);
        sends('{`CMD_SPD, `CMD_UNT});
        check("untalk", talk_on, 1'b0);
    endtask

    task automatic t_parallel();
        logic s;
        for (int i = 0; i < 8; i++) begin
            s = i[0];
            sends('{`CMD_UNL, {2'b01, ADDR}, `CMD_PPC, {3'b110, s, 3'(i)}});
            check("pp cfg", {pp_configured, pp_enabled}, 2'b11);
            ppoll(s, 8'h01 << i);
            ppoll(!s, 8'h00);
            ppoll(s, 8'h01 << i);
        end
    endtask

    task automatic t_disable();
        // Disable without selection leaves the last configuration answering
        sends('{`CMD_UNL, `CMD_PPC, `CMD_PPD});
        check("unsel ppd", {pp_configured, pp_enabled}, 2'b11);
        ppoll(1'b1, 8'h80);
        sends('{`CMD_UNL, {2'b01, ADDR}, `CMD_PPC, `CMD_PPD});
        check("ppd state", {pp_configured, pp_enabled}, 2'b10);
        ppoll(1'b1, 8'h00);
        sends('{`CMD_UNL, {2'b01, ADDR}, `CMD_PPC, 7'h6f, `CMD_PPU});
        check("ppu state", {pp_configured, pp_enabled}, 2'b00);
        ppoll(1'b1, 8'h00);
    endtask

    task automatic t_pass();
        sends('{{2'b10, ADDR}, `CMD_TCT});
        check("early cic", {i_cic, c_cic}, 2'b01);
        cmd(OP_RELEASE, 8'h00);
        repeat (6) @(negedge clk);
        check("cic pass", {i_cic, c_cic, cmd_ready}, 3'b100);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rd_valid === 1'b1) rd_got <= rd_data;
        if (polled_w === 1'b1) poll_cnt <= poll_cnt + 4'h1;
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        sys_rst = 1'b1;
        svc_req = 1'b0;
        svc_reason = 7'h00;
        ist = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = OP_SEND;
        cmd_data = 8'h00;
        rd_got = 8'h00;
        poll_cnt = 4'h0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        t_serial();
        t_parallel();
        t_disable();
        t_pass();
        print_verdict();
    end
endmodule
